//--- design/osr_device.sv
/*
 * device end: decodes main-map writes, forwards window writes to the
 * three write-only oscillator registers and drives their fields out.
 * assumes one hclk shared with the host and a word per valid cycle.
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Function
// - oscillator registers reached only through window 0x05
// - window bits 2:0 hold subsystem id 000
// - window bits 6:3 hold oscillator register address
// - register data starts at window bit 7
// - tuning bit 0 selects calibration voltage
// - tuning bits 8:1 pick sub-band, reset 16
// - power bits 1:0 set main output level
// - power bits 4:2 set oscillator bias
// - power bits 6:5 set divided output level
// - host writes zero to power bit 7
// - power bit 8 turns output divider on
// - divide ratio only acts with divider on
// - divider bits 2:0 pick divide 128 to 1
// - divider bit 3 powers oscillator down
// - oscillator registers are write-only, no read-back
// - host writes highest oscillator address first
// - tuning write may be skipped without band change
// - first programming writes zero to window
// - final write 0x03 or 0x04 starts update
// - manual band clears calibration bit first
module osr_device (
    osr_link_if.device link,                 // writes from the host
    input wire logic hclk,                   // 40 MHz clock
    input wire logic hresetn,                // async reset, active low
    output logic cal_voltage_sel,            // tune from calibration
    output logic [7:0] subband_select,       // 0 highest band
    output logic [1:0] rf_power_code,        // main output level
    output logic [2:0] bias_code,            // oscillator bias
    output logic [1:0] div_power_code,       // divided output level
    output logic diff_divider_on,            // output divider powered
    output logic [2:0] divide_ratio_code,    // stored ratio code
    output logic [7:0] divide_factor,        // active ratio, 0 if off
    output logic oscillator_power_down,      // oscillator off
    output logic freq_update,                // update start pulse
    output logic autocal_armed,              // zero window seen
    output logic osc_write,                  // register taken pulse
    output logic osc_ignored                 // window write dropped
);
    ////////////////////////////////////////////////////////////////////
    // window decode

    logic win_wr;
    logic [osr_pkg::SUB_ID_W-1:0] sub_id;
    logic [osr_pkg::SUB_ADDR_W-1:0] sub_addr;
    logic [osr_pkg::SUB_DATA_W-1:0] sub_data;
    logic id_ok;
    logic hit_tuning;
    logic hit_power;
    logic hit_divider;
    logic final_wr;

    // other main-map addresses never touch the oscillator registers
    assign win_wr = link.mw_valid &&
        (link.mw_addr == osr_pkg::WIN_ADDR);
    assign sub_id = link.mw_data[osr_pkg::SUB_ID_LSB +:
        osr_pkg::SUB_ID_W];
    assign sub_addr = link.mw_data[osr_pkg::SUB_ADDR_LSB +:
        osr_pkg::SUB_ADDR_W];
    assign sub_data = link.mw_data[osr_pkg::SUB_DATA_LSB +:
        osr_pkg::SUB_DATA_W];
    assign id_ok = (sub_id == osr_pkg::OSC_ID);
    assign hit_tuning = win_wr && id_ok &&
        (sub_addr == osr_pkg::REG_TUNING);
    assign hit_power = win_wr && id_ok &&
        (sub_addr == osr_pkg::REG_POWER);
    assign hit_divider = win_wr && id_ok &&
        (sub_addr == osr_pkg::REG_DIVIDER);
    assign final_wr = link.mw_valid &&
        ((link.mw_addr == osr_pkg::INT_FINAL_ADDR) ||
         (link.mw_addr == osr_pkg::FRAC_FINAL_ADDR));

    ////////////////////////////////////////////////////////////////////
    // oscillator registers; no path leads back to the link

    logic [8:0] reg_tuning;
    logic [8:0] reg_power;
    logic [8:0] reg_divider;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_tuning <= osr_pkg::TUNING_RST;
        end else if (hit_tuning) begin
            reg_tuning <= sub_data;
        end
    end

    // bit 7 is stored as written; nothing below reads it, so a host
    // slip there cannot disturb the outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_power <= osr_pkg::POWER_RST;
        end else if (hit_power) begin
            reg_power <= sub_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_divider <= osr_pkg::DIVIDER_RST;
        end else if (hit_divider) begin
            reg_divider <= sub_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // field outputs, straight from the registers

    assign cal_voltage_sel = reg_tuning[osr_pkg::CAL_BIT];
    assign subband_select = reg_tuning[osr_pkg::BAND_LSB +:
        osr_pkg::BAND_W];
    assign rf_power_code = reg_power[osr_pkg::RFPWR_LSB +: 2];
    assign bias_code = reg_power[osr_pkg::BIAS_LSB +: 3];
    assign div_power_code = reg_power[osr_pkg::DIVPWR_LSB +: 2];
    assign diff_divider_on = reg_power[osr_pkg::DIV_ON_BIT];
    assign divide_ratio_code = reg_divider[osr_pkg::RATIO_LSB +:
        3];
    assign oscillator_power_down =
        reg_divider[osr_pkg::OSC_PD_BIT];

    ////////////////////////////////////////////////////////////////////
    // active divide factor, registered one cycle behind the fields

    logic [7:0] next_divide_factor;

    // code 0 is divide by 128 and code 7 is bypass
    always_comb begin
        next_divide_factor = 8'h00;
        if (diff_divider_on) begin
            next_divide_factor = 8'h80 >> divide_ratio_code;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            divide_factor <= 8'h00;
        end else begin
            divide_factor <= next_divide_factor;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frequency update start

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_update <= 1'b0;
        end else begin
            freq_update <= final_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // autocalibration arm: a zero window word arms it, any later
    // nonzero tuning write disarms it, manual band or not

    logic zero_win;

    assign zero_win = win_wr && (link.mw_data == '0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            autocal_armed <= 1'b0;
        end else if (zero_win) begin
            autocal_armed <= 1'b1;
        end else if (hit_tuning) begin
            autocal_armed <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write activity pulses

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_write <= 1'b0;
        end else begin
            osc_write <= hit_tuning || hit_power || hit_divider;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_ignored <= 1'b0;
        end else begin
            osc_ignored <= win_wr && !(hit_tuning || hit_power ||
                hit_divider);
        end
    end
endmodule
`default_nettype wire

//--- design/osr_host.sv
/*
 * host end: an ahb-lite slave with its own command registers that
 * turns software orders into main-map writes on the link, including
 * the ordered oscillator programming sequence.
 * assumes one hclk shared with the device and a single ahb master.
 */
`timescale 1ns/1ps
`default_nettype none
module osr_host (
    osr_link_if.host link,                   // writes to the device
    input wire logic hclk,                   // 40 MHz clock
    input wire logic hresetn,                // async reset, active low
    input wire logic hsel,                   // slave select
    input wire logic [31:0] haddr,           // byte address
    input wire logic [1:0] htrans,           // transfer type
    input wire logic hwrite,                 // write when high
    input wire logic [2:0] hsize,            // word only
    input wire logic hready,                 // bus ready in
    input wire logic [31:0] hwdata,          // write data
    output logic hreadyout,                  // always ready
    output logic hresp,                      // always okay
    output logic [31:0] hrdata               // read data
);
    ////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states

    logic ap_wr;
    logic ap_rd;
    logic [7:0] ap_addr;
    logic [3:0] ctrl;
    logic [8:0] tune_cfg;
    logic [8:0] power_cfg;
    logic [8:0] div_cfg;
    logic [23:0] final_data;
    logic [28:0] raw_wr;
    logic [7:0] wr_count;
    logic start_req;
    logic raw_req;
    osr_pkg::osr_state_t state;
    osr_pkg::osr_state_t next_state;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr <= 1'b0;
            ap_rd <= 1'b0;
            ap_addr <= 8'h00;
        end else if (hready) begin
            ap_wr <= hsel && htrans[1] && hwrite;
            ap_rd <= hsel && htrans[1] && !hwrite;
            ap_addr <= haddr[7:0];
        end
    end

    // orders arriving while a sequence runs are dropped, not queued
    assign start_req = ap_wr && (ap_addr == osr_pkg::CTRL_OFS) &&
        hwdata[osr_pkg::CTRL_START] && (state == osr_pkg::ST_IDLE);
    assign raw_req = ap_wr && (ap_addr == osr_pkg::RAW_WR_OFS) &&
        (state == osr_pkg::ST_IDLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= osr_pkg::CTRL_RST;
            tune_cfg <= osr_pkg::TUNING_RST;
            power_cfg <= osr_pkg::POWER_RST;
            div_cfg <= osr_pkg::DIVIDER_RST;
            final_data <= 24'h000000;
            raw_wr <= 29'h0;
        end else if (ap_wr) begin
            unique case (ap_addr)
                osr_pkg::CTRL_OFS: ctrl <= hwdata[4:1];
                osr_pkg::TUNE_CFG_OFS: tune_cfg <= hwdata[8:0];
                osr_pkg::POWER_CFG_OFS: power_cfg <= hwdata[8:0];
                osr_pkg::DIV_CFG_OFS: div_cfg <= hwdata[8:0];
                osr_pkg::FINAL_DATA_OFS: final_data <= hwdata[23:0];
                osr_pkg::RAW_WR_OFS: raw_wr <= hwdata[28:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        hrdata = 32'h00000000;
        if (ap_rd) begin
            unique case (ap_addr)
                osr_pkg::CTRL_OFS: hrdata = {27'h0, ctrl, 1'b0};
                osr_pkg::TUNE_CFG_OFS: hrdata = {23'h0, tune_cfg};
                osr_pkg::POWER_CFG_OFS: hrdata = {23'h0, power_cfg};
                osr_pkg::DIV_CFG_OFS: hrdata = {23'h0, div_cfg};
                osr_pkg::FINAL_DATA_OFS: hrdata = {8'h0, final_data};
                osr_pkg::RAW_WR_OFS: hrdata = {3'h0, raw_wr};
                osr_pkg::STATUS_OFS: hrdata = {16'h0, wr_count, 7'h0,
                    state != osr_pkg::ST_IDLE};
                default: hrdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer: divider, power, tuning, zero window, final write

    function automatic logic [23:0] win_word(input logic [3:0] a,
                                             input logic [8:0] d);
        win_word = {8'h00, d, a, osr_pkg::OSC_ID};
    endfunction

    always_comb begin
        next_state = state;
        unique case (state)
            osr_pkg::ST_IDLE: begin
                if (start_req) begin
                    next_state = osr_pkg::ST_DIV;
                end else if (raw_req) begin
                    next_state = osr_pkg::ST_RAW;
                end
            end
            osr_pkg::ST_DIV: next_state = osr_pkg::ST_POWER;
            osr_pkg::ST_POWER: begin
                if (ctrl[osr_pkg::CTRL_TUNE - 1]) begin
                    next_state = osr_pkg::ST_TUNE;
                end else if (ctrl[osr_pkg::CTRL_FIRST - 1]) begin
                    next_state = osr_pkg::ST_ZERO;
                end else begin
                    next_state = osr_pkg::ST_FINAL;
                end
            end
            osr_pkg::ST_TUNE: begin
                if (ctrl[osr_pkg::CTRL_FIRST - 1]) begin
                    next_state = osr_pkg::ST_ZERO;
                end else begin
                    next_state = osr_pkg::ST_FINAL;
                end
            end
            osr_pkg::ST_ZERO: next_state = osr_pkg::ST_FINAL;
            osr_pkg::ST_FINAL: next_state = osr_pkg::ST_IDLE;
            osr_pkg::ST_RAW: next_state = osr_pkg::ST_IDLE;
            default: next_state = osr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= osr_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link word, registered one cycle behind its state

    logic [8:0] pwr_clean;
    logic [8:0] tune_clean;

    always_comb begin
        pwr_clean = power_cfg;
        pwr_clean[osr_pkg::PWR_RSVD_BIT] = 1'b0;
        tune_clean = tune_cfg;
        if (ctrl[osr_pkg::CTRL_MANUAL - 1]) begin
            tune_clean[osr_pkg::CAL_BIT] = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.mw_valid <= 1'b0;
            link.mw_addr <= 5'h00;
            link.mw_data <= 24'h000000;
        end else begin
            link.mw_valid <= (state != osr_pkg::ST_IDLE);
            link.mw_addr <= osr_pkg::WIN_ADDR;
            unique case (state)
                osr_pkg::ST_DIV: link.mw_data <=
                    win_word(osr_pkg::REG_DIVIDER, div_cfg);
                osr_pkg::ST_POWER: link.mw_data <=
                    win_word(osr_pkg::REG_POWER, pwr_clean);
                osr_pkg::ST_TUNE: link.mw_data <=
                    win_word(osr_pkg::REG_TUNING, tune_clean);
                osr_pkg::ST_ZERO: link.mw_data <= 24'h000000;
                osr_pkg::ST_FINAL: begin
                    link.mw_addr <= ctrl[osr_pkg::CTRL_FRAC - 1] ?
                        osr_pkg::FRAC_FINAL_ADDR :
                        osr_pkg::INT_FINAL_ADDR;
                    link.mw_data <= final_data;
                end
                osr_pkg::ST_RAW: begin
                    link.mw_addr <= raw_wr[osr_pkg::RAW_ADDR_LSB +: 5];
                    link.mw_data <= raw_wr[23:0];
                end
                default: link.mw_data <= 24'h000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_count <= 8'h00;
        end else if (state != osr_pkg::ST_IDLE) begin
            wr_count <= wr_count + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- dv/osc_subsystem_indirect_regs_tb.sv
/* self-checking bench: host and device ends joined by the link,
   software orders given over ahb-lite. assumes the osr_pkg constants. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module osc_subsystem_indirect_regs_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, cal_voltage_sel, diff_divider_on;
    logic oscillator_power_down, freq_update, autocal_armed;
    logic osc_write, osc_ignored;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [7:0] subband_select, divide_factor;
    logic [1:0] rf_power_code, div_power_code;
    logic [2:0] bias_code, divide_ratio_code;
    logic [8:0] log_q[$];
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    always #12.5 hclk = ~hclk;
    osr_link_if link();
    osr_host osr_host_i(.link(link), .hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hreadyout,
        .hresp, .hrdata);
    osr_device osr_device_i(.link(link), .hclk, .hresetn, .cal_voltage_sel,
        .subband_select, .rf_power_code, .bias_code, .div_power_code,
        .diff_divider_on, .divide_ratio_code, .divide_factor,
        .oscillator_power_down, .freq_update, .autocal_armed, .osc_write,
        .osc_ignored);
    osr_link_asserts osr_link_asserts_i(.hclk, .hresetn,
        .mw_valid(link.mw_valid), .mw_addr(link.mw_addr),
        .mw_data(link.mw_data), .cal_voltage_sel, .subband_select,
        .rf_power_code, .bias_code, .div_power_code, .diff_divider_on,
        .divide_ratio_code, .divide_factor, .oscillator_power_down,
        .freq_update, .osc_write, .osc_ignored);
    ////////////////////////////////////////////////////////////////////////
    // log of link words: main address, plus window sub-address
    always @(posedge hclk) begin
        cycles++;
        if (link.mw_valid === 1'b1)
            log_q.push_back({link.mw_addr,
                link.mw_addr == 5'h05 ? link.mw_data[6:3] : 4'h0});
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // returns just after the edge at which the device took the word
    task automatic raw(input logic [4:0] a, input logic [23:0] d);
        int n;
        ahb(1'b1, osr_pkg::RAW_WR_OFS, {3'h0, a, d});
        n = 0;
        while (link.mw_valid !== 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        #1;
    endtask
    function automatic logic [23:0] wword(input logic [3:0] s,
                                          input logic [8:0] v);
        return {8'h0, v, s, 3'h0};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK({subband_select, cal_voltage_sel}, 9'h020)
        `CHK({rf_power_code, bias_code, div_power_code}, 7'h00)
        `CHK({diff_divider_on, divide_ratio_code}, 4'h0)
        `CHK(oscillator_power_down, 1'b0)
        ahb(1'b0, osr_pkg::TUNE_CFG_OFS, 32'h0);
        `CHK(rd, 32'h020)
        ahb(1'b0, 8'h40, 32'h0);
        `CHK({hresp, rd}, 33'h0)
        $display("test reset done");
    endtask
    task automatic t_power();
        raw(5'h05, wword(4'h1, 9'h07f));
        `CHK({div_power_code, bias_code}, 5'h1f)
        `CHK({rf_power_code, diff_divider_on}, 3'h6)
        raw(5'h05, wword(4'h1, 9'h17f));
        `CHK(diff_divider_on, 1'b1)
        for (int i = 0; i < 8; i++) begin
            raw(5'h05, wword(4'h2, 9'(i)));
            `CHK(divide_ratio_code, 3'(i))
            @(posedge hclk);
            #1;
            `CHK(divide_factor, 8'h80 >> i)
        end
        raw(5'h05, wword(4'h1, 9'h07f));
        @(posedge hclk);
        #1;
        `CHK(divide_factor, 8'h00)
        raw(5'h05, wword(4'h2, 9'h008));
        `CHK(oscillator_power_down, 1'b1)
        $display("test power and divider done");
    endtask
    task automatic t_tune();
        raw(5'h05, 24'h00cd00);
        `CHK({osc_write, subband_select, cal_voltage_sel}, 10'h39a)
        raw(5'h05, wword(4'h0, 9'h001));
        `CHK({subband_select, cal_voltage_sel}, 9'h001)
        raw(5'h05, {8'h0, 9'h0ff, 4'h0, 3'h1});
        `CHK({osc_ignored, subband_select}, 9'h100)
        raw(5'h05, wword(4'h3, 9'h0ff));
        `CHK({osc_ignored, subband_select}, 9'h100)
        raw(5'h06, wword(4'h0, 9'h0ff));
        `CHK({osc_write, subband_select}, 9'h000)
        $display("test tuning done");
    endtask
    // programs the registers and starts a sequence; exp holds the link log
    task automatic t_seq(input logic [7:0] ctrl, input logic [44:0] exp,
                         input int k);
        int n;
        log_q.delete();
        ahb(1'b1, osr_pkg::DIV_CFG_OFS, 32'h001);
        ahb(1'b1, osr_pkg::POWER_CFG_OFS, 32'h1ff);
        ahb(1'b1, osr_pkg::TUNE_CFG_OFS, 32'h19b);
        ahb(1'b1, osr_pkg::FINAL_DATA_OFS, 32'h123);
        ahb(1'b1, osr_pkg::CTRL_OFS, {24'h0, ctrl});
        n = 0;
        while (freq_update !== 1'b1 && n < 40) begin
            @(posedge hclk);
            n++;
        end
        repeat (2) @(posedge hclk);
        `CHK(log_q.size(), k)
        for (int i = 0; i < k; i++)
            `CHK(log_q[i], exp[9*i +: 9])
        `CHK({div_power_code, bias_code, rf_power_code}, 7'h7f)
        `CHK({diff_divider_on, divide_factor}, 9'h140)
        if (ctrl[2])
            `CHK(autocal_armed, 1'b1)
        // manual band: cal bit cleared on the way, autocal disarmed
        if (ctrl[4])
            `CHK({autocal_armed, subband_select, cal_voltage_sel}, 10'h19a)
        $display("test sequence %0h done", ctrl);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        t_reset();
        t_power();
        t_tune();
        t_seq(8'h0f, {9'h040, 9'h050, 9'h050, 9'h051, 9'h052}, 5);
        t_seq(8'h01, {18'h0, 9'h030, 9'h051, 9'h052}, 3);
        t_seq(8'h13, {9'h0, 9'h030, 9'h050, 9'h051, 9'h052}, 4);
        results();
    end
endmodule
`default_nettype wire

//--- dv/osr_link_asserts.sv
/* checker for the link between the host and device ends.
   assumes one clock and takes the device outputs as plain inputs. */
`timescale 1ns/1ps
`default_nettype none
module osr_link_asserts (
    input wire logic hclk, // clock
    input wire logic hresetn, // async reset, active low
    input wire logic mw_valid, // word present
    input wire logic [4:0] mw_addr, // main-map address
    input wire logic [23:0] mw_data, // write data
    input wire logic cal_voltage_sel, // tuning bit 0
    input wire logic [7:0] subband_select, // band
    input wire logic [1:0] rf_power_code, // output level
    input wire logic [2:0] bias_code, // bias
    input wire logic [1:0] div_power_code, // divided level
    input wire logic diff_divider_on, // divider on
    input wire logic [2:0] divide_ratio_code, // ratio code
    input wire logic [7:0] divide_factor, // active ratio
    input wire logic oscillator_power_down, // oscillator off
    input wire logic freq_update, // update pulse
    input wire logic osc_write, // taken pulse
    input wire logic osc_ignored // dropped pulse
);
    logic win;
    logic hit;
    logic fin;
    assign win = mw_valid && mw_addr == osr_pkg::WIN_ADDR;
    assign hit = win && mw_data[2:0] == 3'h0 && mw_data[6:3] <= 4'h2;
    assign fin = mw_valid && (mw_addr == 5'h03 || mw_addr == 5'h04);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////
    AST_WIN_HIT:
    assert property (hit |=> osc_write && !osc_ignored)
        else $error("window write not taken");
    AST_WIN_DROP:
    assert property (win && !hit |=> osc_ignored && !osc_write)
        else $error("foreign window write not dropped");
    AST_TUNE:
    assert property (hit && mw_data[6:3] == 4'h0 |=>
        {subband_select, cal_voltage_sel} == $past(mw_data[15:7]))
        else $error("tuning fields wrong");
    AST_POWER:
    assert property (hit && mw_data[6:3] == 4'h1 |=>
        {div_power_code, bias_code, rf_power_code} == $past(mw_data[13:7])
        && diff_divider_on == $past(mw_data[15]))
        else $error("power fields wrong");
    AST_DIV:
    assert property (hit && mw_data[6:3] == 4'h2 |=>
        {oscillator_power_down, divide_ratio_code} == $past(mw_data[10:7]))
        else $error("divider fields wrong");
    AST_RSVD:
    assert property (hit && mw_data[6:3] == 4'h1 |-> !mw_data[14])
        else $error("reserved power bit sent high");
    AST_UPD:
    assert property (1'b1 |=> freq_update == $past(fin))
        else $error("update pulse does not follow final write");
    AST_FACTOR:
    assert property (1'b1 |=> divide_factor == ($past(diff_divider_on) ?
        8'h80 >> $past(divide_ratio_code) : 8'h00))
        else $error("divide factor wrong");
    AST_STILL:
    assert property (!mw_valid |=> $stable(subband_select)
        && $stable(oscillator_power_down))
        else $error("register moved without a write");
    cover property (hit && mw_data[6:3] == 4'h2);
    cover property (osc_ignored);
    cover property (freq_update);
endmodule
`default_nettype wire

//--- inc/osr_link_if.sv
/*
 * link between the host controller and the synthesizer's main map:
 * one write word per cycle, no read path.
 * assumes both ends share hclk; serial framing is outside this pair.
 */
`timescale 1ns/1ps
`default_nettype none
interface osr_link_if;
    logic mw_valid;
    logic [osr_pkg::MADDR_W-1:0] mw_addr;
    logic [osr_pkg::MDATA_W-1:0] mw_data;

    modport host (
        output mw_valid,
        output mw_addr,
        output mw_data
    );
    modport device (
        input mw_valid,
        input mw_addr,
        input mw_data
    );
endinterface
`default_nettype wire

//--- inc/osr_pkg.sv
/*
 * constants shared by both ends of the oscillator register path:
 * main-map addresses, window layout, oscillator register fields,
 * reset values, the controller's own register map and its states.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package osr_pkg;
    // main register map seen on the link
    localparam int MADDR_W = 5;
    localparam int MDATA_W = 24;
    localparam logic [4:0] WIN_ADDR = 5'h05;
    localparam logic [4:0] INT_FINAL_ADDR = 5'h03;
    localparam logic [4:0] FRAC_FINAL_ADDR = 5'h04;
    // window register layout
    localparam int SUB_ID_LSB = 0;
    localparam int SUB_ID_W = 3;
    localparam int SUB_ADDR_LSB = 3;
    localparam int SUB_ADDR_W = 4;
    localparam int SUB_DATA_LSB = 7;
    localparam int SUB_DATA_W = 9;
    localparam logic [2:0] OSC_ID = 3'h0;
    // oscillator register addresses
    localparam logic [3:0] REG_TUNING = 4'h0;
    localparam logic [3:0] REG_POWER = 4'h1;
    localparam logic [3:0] REG_DIVIDER = 4'h2;
    // tuning register fields
    localparam int CAL_BIT = 0;
    localparam int BAND_LSB = 1;
    localparam int BAND_W = 8;
    localparam logic [8:0] TUNING_RST = 9'h020;
    // power register fields
    localparam int RFPWR_LSB = 0;
    localparam int BIAS_LSB = 2;
    localparam int DIVPWR_LSB = 5;
    localparam int PWR_RSVD_BIT = 7;
    localparam int DIV_ON_BIT = 8;
    localparam logic [8:0] POWER_RST = 9'h000;
    // divider register fields
    localparam int RATIO_LSB = 0;
    localparam int OSC_PD_BIT = 3;
    localparam logic [8:0] DIVIDER_RST = 9'h000;
    // controller registers, byte offsets on ahb-lite
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TUNE_CFG_OFS = 8'h04;
    localparam logic [7:0] POWER_CFG_OFS = 8'h08;
    localparam logic [7:0] DIV_CFG_OFS = 8'h0c;
    localparam logic [7:0] FINAL_DATA_OFS = 8'h10;
    localparam logic [7:0] RAW_WR_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    // ctrl bits, plus the raw write address position
    localparam int CTRL_START = 0;
    localparam int CTRL_TUNE = 1;
    localparam int CTRL_FIRST = 2;
    localparam int CTRL_FRAC = 3;
    localparam int CTRL_MANUAL = 4;
    localparam int RAW_ADDR_LSB = 24;
    localparam logic [3:0] CTRL_RST = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DIV = 3'b001,
        ST_POWER = 3'b010,
        ST_TUNE = 3'b011,
        ST_ZERO = 3'b100,
        ST_FINAL = 3'b101,
        ST_RAW = 3'b110
    } osr_state_t;
endpackage
